// ### hdl/interrupt_mask_deferral_ctrl.v
// mask/deferral control register with interrupt summary, look-ahead ring scan and byte lanes
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`include "imdc_regs.vh"

// Behaviour
// R1 - missed-frame mask blocks missed-frame event
// R2 - memory-error mask blocks memory-error event
// R3 - receive mask blocks receive-complete event
// R4 - transmit mask blocks transmit-complete event
// R5 - init-done mask blocks init-done event
// R6 - underflow stops transmitter when disable clear
// R7 - underflow with disable set: rescan, retransmit
// R8 - look-ahead adds receive event after first buffer
// R9 - look-ahead starts packets at start-of-packet descriptors
// R10 - after last descriptor, scan ignoring ownership
// R11 - owned non-start descriptors get ownership cleared
// R12 - host-owned start descriptor: stop, poll periodically
// R13 - owned start descriptor: stop, hold, await frame
// R14 - two-part deferral disabled when bit set
// R15 - modified back-off used when bit set
// R16 - big endian maps bus bytes reversed
// R17 - little endian maps bus bytes straight
// R18 - swap applies to FIFO data only
// R19 - host keeps swap bit zero on PCI
// R20 - bits 1-0 store value, no function
// R21 - bits 15-13 and 7 read zero
// R22 - reset clears bits; stop leaves them
// R23 - interrupt output when summary and enable
module interrupt_mask_deferral_ctrl (
  // clock and reset
  input  wire        CLOCK_I,
  input  wire        RST_N_I,
  // register port
  input  wire [3:0]  ADDR_I,
  input  wire [31:0] WDATA_I,
  input  wire        WR_I,
  input  wire        RD_I,
  output reg  [31:0] RDATA_O,
  // event sources, one-cycle pulses from the engines
  input  wire        MISSED_FRAME_I,
  input  wire        MEMORY_ERROR_I,
  input  wire        TRANSMIT_DONE_I,
  input  wire        INIT_DONE_I,
  input  wire        TRANSMIT_UNDERFLOW_I,
  // receive engine handshakes
  input  wire        RX_FIRST_WRITTEN_I,
  input  wire        RX_LAST_WRITTEN_I,
  input  wire        RX_FRAME_ARRIVED_I,
  // descriptor read port of the ring scan
  input  wire        DESC_VALID_I,
  input  wire        DESC_OWNED_I,
  input  wire        DESC_START_I,
  input  wire [31:0] DESC_WORD_I,
  // fifo data lanes
  input  wire [31:0] FIFO_BUS_I,
  input  wire [31:0] FIFO_MEM_I,
  // outputs to the rest of the controller
  output reg         INTERRUPT_O,
  output reg         SUMMARY_O,
  output reg         TRANSMIT_ON_O,
  output reg         TX_RESCAN_O,
  output reg         TWO_PART_OFF_O,
  output reg         MOD_BACKOFF_O,
  output reg         DESC_FETCH_O,
  output reg         DESC_ADVANCE_O,
  output reg         DESC_CLEAR_OWN_O,
  output reg         RX_START_SEEN_O,
  output reg  [31:0] RX_HELD_DESC_O,
  output reg  [31:0] FIFO_TO_MEM_O,
  output reg  [31:0] FIFO_TO_BUS_O
);

  reg  [31:0] maskctl;
  reg  [4:0]  events;
  reg         irq_enable;
  reg         tx_enabled;
  reg  [2:0]  scan;
  reg  [2:0]  next_scan;
  reg  [15:0] poll_cnt;
  reg         soft_rst;
  wire        wr_mask  = WR_I && (ADDR_I == `IMDC_OFF_MASKCTL);
  wire        wr_evt   = WR_I && (ADDR_I == `IMDC_OFF_EVENTS);
  wire        wr_ctl   = WR_I && (ADDR_I == `IMDC_OFF_CONTROL);
  wire        stop_cmd = wr_ctl && WDATA_I[`IMDC_CTL_STOP];
  wire        lookahead = maskctl[`IMDC_BIT_LOOKAHEAD];
  wire        swap      = maskctl[`IMDC_BIT_SWAP];
  wire [4:0]  ev_mask   = {maskctl[`IMDC_BIT_MISS_MASK], maskctl[`IMDC_BIT_MEMERR_MASK],
                           maskctl[`IMDC_BIT_RX_MASK], maskctl[`IMDC_BIT_TX_MASK],
                           maskctl[`IMDC_BIT_INIT_MASK]};
  // reload value of the host poll timer, cut to the timer width on purpose
  localparam [31:0] POLL_LOAD = `IMDC_POLL_CYC - 1;
  wire        rx_event  = RX_LAST_WRITTEN_I || (lookahead && RX_FIRST_WRITTEN_I); // see R8
  wire [4:0]  ev_set    = {MISSED_FRAME_I, MEMORY_ERROR_I, rx_event,
                           TRANSMIT_DONE_I, INIT_DONE_I};
  // masked events never reach the summary
  wire        summary   = |(events & ~ev_mask); // see R1 see R2 see R3 see R4 see R5
  wire [31:0] swapped_bus;
  wire [31:0] swapped_mem;

  // mask register: reset clears it, stop leaves it, reserved bits 15-13 and 7 stay zero
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      maskctl <= `IMDC_MASKCTL_RESET; // see R22
    end else if (soft_rst) begin
      maskctl <= `IMDC_MASKCTL_RESET; // see R22
    end else if (wr_mask) begin
      maskctl <= WDATA_I & `IMDC_MASKCTL_WMASK; // see R20 see R21
    end
  end

  // sticky event flags; a set in the clear cycle wins, stop clears them
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      events <= 5'h00;
    end else if (soft_rst || stop_cmd) begin
      events <= ev_set;
    end else if (wr_evt) begin
      events <= (events & ~WDATA_I[4:0]) | ev_set;
    end else begin
      events <= events | ev_set;
    end
  end

  // soft reset pulse, global enable and transmitter state
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      soft_rst   <= 1'b0;
      irq_enable <= 1'b0;
      tx_enabled <= 1'b0;
    end else begin
      soft_rst <= wr_ctl && WDATA_I[`IMDC_CTL_SRESET];
      if (soft_rst || stop_cmd) begin
        irq_enable <= 1'b0;
        tx_enabled <= 1'b0;
      end else begin
        if (wr_ctl) begin
          irq_enable <= WDATA_I[`IMDC_CTL_IRQ_EN];
        end
        if (TRANSMIT_UNDERFLOW_I && !maskctl[`IMDC_BIT_UFLOSTOP]) begin
          tx_enabled <= 1'b0; // see R6
        end else if (wr_ctl && WDATA_I[`IMDC_CTL_TX_ON]) begin
          tx_enabled <= 1'b1;
        end
      end
    end
  end

  // look-ahead ring scan: search for the next start descriptor after a packet
  always @* begin
    next_scan = scan;
    case (scan)
      `IMDC_SCAN_IDLE: begin
        if (lookahead && RX_LAST_WRITTEN_I) begin
          next_scan = `IMDC_SCAN_CHECK; // see R10
        end
      end
      `IMDC_SCAN_CHECK: begin
        if (!lookahead) begin
          next_scan = `IMDC_SCAN_IDLE;
        end else if (DESC_VALID_I) begin
          if (DESC_START_I && DESC_OWNED_I) begin
            next_scan = `IMDC_SCAN_HOLD; // see R13
          end else if (DESC_START_I) begin
            next_scan = `IMDC_SCAN_POLL; // see R12
          end else if (DESC_OWNED_I) begin
            next_scan = `IMDC_SCAN_CLEAR; // see R11
          end
        end
      end
      `IMDC_SCAN_CLEAR: next_scan = `IMDC_SCAN_CHECK;
      `IMDC_SCAN_POLL: begin
        if (poll_cnt == 16'h0000) begin
          next_scan = `IMDC_SCAN_CHECK; // see R12
        end
      end
      `IMDC_SCAN_HOLD: begin
        if (RX_FRAME_ARRIVED_I || !lookahead) begin
          next_scan = `IMDC_SCAN_IDLE; // see R13
        end
      end
      default: next_scan = `IMDC_SCAN_IDLE;
    endcase
  end

  // scan state, poll timer and descriptor strobes
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scan             <= `IMDC_SCAN_IDLE;
      poll_cnt         <= 16'h0000;
      DESC_FETCH_O     <= 1'b0;
      DESC_ADVANCE_O   <= 1'b0;
      DESC_CLEAR_OWN_O <= 1'b0;
      RX_START_SEEN_O  <= 1'b0;
      RX_HELD_DESC_O   <= 32'h00000000;
    end else if (soft_rst) begin
      scan             <= `IMDC_SCAN_IDLE;
      poll_cnt         <= 16'h0000;
      DESC_FETCH_O     <= 1'b0;
      DESC_ADVANCE_O   <= 1'b0;
      DESC_CLEAR_OWN_O <= 1'b0;
      RX_START_SEEN_O  <= 1'b0;
    end else begin
      scan <= next_scan;
      // fetch is requested while the scan waits on a descriptor word
      DESC_FETCH_O <= (next_scan == `IMDC_SCAN_CHECK); // see R9
      // advance on every non-start descriptor, owned or not
      DESC_ADVANCE_O <= (scan == `IMDC_SCAN_CHECK) && DESC_VALID_I && lookahead
                        && !DESC_START_I; // see R10 see R11
      DESC_CLEAR_OWN_O <= (scan == `IMDC_SCAN_CHECK) && DESC_VALID_I && lookahead
                          && !DESC_START_I && DESC_OWNED_I; // see R11
      RX_START_SEEN_O <= (next_scan == `IMDC_SCAN_HOLD); // see R9
      if (scan == `IMDC_SCAN_CHECK && next_scan == `IMDC_SCAN_HOLD) begin
        RX_HELD_DESC_O <= DESC_WORD_I; // see R13
      end
      // poll timer reloads on entry, counts down while waiting on the host
      if (scan == `IMDC_SCAN_CHECK && next_scan == `IMDC_SCAN_POLL) begin
        poll_cnt <= POLL_LOAD[15:0]; // see R12
      end else if (scan == `IMDC_SCAN_POLL && poll_cnt != 16'h0000) begin
        poll_cnt <= poll_cnt - 16'h0001;
      end
    end
  end

  // fifo byte lanes, one per byte; only fifo data takes this path
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : lane
      assign swapped_bus[8*b+7:8*b] = swap ? FIFO_BUS_I[8*(3-b)+7:8*(3-b)]
                                           : FIFO_BUS_I[8*b+7:8*b]; // see R16 see R17
      assign swapped_mem[8*b+7:8*b] = swap ? FIFO_MEM_I[8*(3-b)+7:8*(3-b)]
                                           : FIFO_MEM_I[8*b+7:8*b]; // see R16 see R17
    end
  endgenerate

  // registered outputs; descriptors and register reads never pass the swap
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      INTERRUPT_O    <= 1'b0;
      SUMMARY_O      <= 1'b0;
      TRANSMIT_ON_O  <= 1'b0;
      TX_RESCAN_O    <= 1'b0;
      TWO_PART_OFF_O <= 1'b0;
      MOD_BACKOFF_O  <= 1'b0;
      FIFO_TO_MEM_O  <= 32'h00000000;
      FIFO_TO_BUS_O  <= 32'h00000000;
      RDATA_O        <= 32'h00000000;
    end else begin
      SUMMARY_O      <= summary;
      INTERRUPT_O    <= summary && irq_enable; // see R23
      TRANSMIT_ON_O  <= tx_enabled;
      // rescan pulse lets the transmitter hunt for the next frame start
      TX_RESCAN_O    <= TRANSMIT_UNDERFLOW_I && maskctl[`IMDC_BIT_UFLOSTOP]
                        && tx_enabled; // see R7
      TWO_PART_OFF_O <= maskctl[`IMDC_BIT_TWOPART]; // see R14
      MOD_BACKOFF_O  <= maskctl[`IMDC_BIT_BACKOFF]; // see R15
      FIFO_TO_MEM_O  <= swapped_bus; // see R18
      FIFO_TO_BUS_O  <= swapped_mem; // see R18
      if (RD_I) begin
        case (ADDR_I)
          `IMDC_OFF_MASKCTL: RDATA_O <= maskctl; // see R21
          `IMDC_OFF_EVENTS:  RDATA_O <= {27'h0000000, events};
          `IMDC_OFF_CONTROL: RDATA_O <= {30'h00000000, tx_enabled, irq_enable};
          `IMDC_OFF_STATUS:  RDATA_O <= {27'h0000000, scan, summary, summary && irq_enable};
          default:           RDATA_O <= 32'h00000000;
        endcase
      end else begin
        RDATA_O <= 32'h00000000;
      end
    end
  end

endmodule

// ### include/imdc_regs.vh
// register offsets, field positions, reset values and timing counts for the mask/deferral block
`ifndef IMDC_REGS_VH
`define IMDC_REGS_VH
`define IMDC_ADDR_W          4
`define IMDC_OFF_MASKCTL     4'h0
`define IMDC_OFF_EVENTS      4'h4
`define IMDC_OFF_CONTROL     4'h8
`define IMDC_OFF_STATUS      4'hC
`define IMDC_MASKCTL_RESET   32'h00000000
`define IMDC_MASKCTL_WMASK   32'h00001F7F
`define IMDC_BIT_MISS_MASK   12
`define IMDC_BIT_MEMERR_MASK 11
`define IMDC_BIT_RX_MASK     10
`define IMDC_BIT_TX_MASK     9
`define IMDC_BIT_INIT_MASK   8
`define IMDC_BIT_UFLOSTOP    6
`define IMDC_BIT_LOOKAHEAD   5
`define IMDC_BIT_TWOPART     4
`define IMDC_BIT_BACKOFF     3
`define IMDC_BIT_SWAP        2
`define IMDC_EVT_MISS        4
`define IMDC_EVT_MEMERR      3
`define IMDC_EVT_RX          2
`define IMDC_EVT_TX          1
`define IMDC_EVT_INIT        0
`define IMDC_CTL_IRQ_EN      0
`define IMDC_CTL_TX_ON       1
`define IMDC_CTL_STOP        2
`define IMDC_CTL_SRESET      3
`define IMDC_POLL_NS         1000
`define IMDC_CLK_NS          5
`define IMDC_POLL_CYC        ((`IMDC_POLL_NS + `IMDC_CLK_NS - 1) / `IMDC_CLK_NS)
`define IMDC_SCAN_IDLE       3'h0
`define IMDC_SCAN_CHECK      3'h1
`define IMDC_SCAN_CLEAR      3'h2
`define IMDC_SCAN_POLL       3'h3
`define IMDC_SCAN_HOLD       3'h4
`endif

// ### sim/interrupt_mask_deferral_ctrl_monitor.sv
// assertion checker bound to the mask/deferral register block
`timescale 1ns/1ps
module imdc_monitor (
  // clock, reset and register port
  input wire        CLOCK_I,
  input wire        RST_N_I,
  input wire [3:0]  ADDR_I,
  input wire [31:0] WDATA_I,
  input wire        WR_I,
  input wire        RD_I,
  input wire [31:0] RDATA_O,
  // event and engine inputs
  input wire        MISSED_FRAME_I,
  input wire        MEMORY_ERROR_I,
  input wire        TRANSMIT_DONE_I,
  input wire        INIT_DONE_I,
  input wire        TRANSMIT_UNDERFLOW_I,
  input wire        RX_LAST_WRITTEN_I,
  input wire        DESC_VALID_I,
  input wire        DESC_OWNED_I,
  input wire        DESC_START_I,
  input wire [31:0] DESC_WORD_I,
  input wire [31:0] FIFO_BUS_I,
  // observed outputs
  input wire        SUMMARY_O,
  input wire        INTERRUPT_O,
  input wire        TRANSMIT_ON_O,
  input wire        DESC_FETCH_O,
  input wire        RX_START_SEEN_O,
  input wire [31:0] RX_HELD_DESC_O,
  input wire [31:0] FIFO_TO_MEM_O
);
  reg  [31:0] m;
  reg  [31:0] emem;
  reg         rd0;
  wire        scan;
  // shadow of the mask register; soft reset clears it, stop leaves it
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      m <= 32'h0;
      emem <= 32'h0;
      rd0 <= 1'b0;
    end else begin
      rd0 <= RD_I && ADDR_I == 4'h0;
      emem <= m[2] ? {FIFO_BUS_I[7:0], FIFO_BUS_I[15:8], FIFO_BUS_I[23:16], FIFO_BUS_I[31:24]}
                   : FIFO_BUS_I;
      if (WR_I && ADDR_I == 4'h0) m <= WDATA_I;
      else if (WR_I && ADDR_I == 4'h8 && WDATA_I[3]) m <= 32'h0;
    end
  end
  // a descriptor is only judged while the scan asks for it
  assign scan = DESC_VALID_I && DESC_FETCH_O && m[5];
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  rsvd_zero_a: assert property (rd0 |-> RDATA_O[15:13] == 3'h0 && !RDATA_O[7])
    else $error("reserved bits read nonzero");
  irq_gate_a: assert property (INTERRUPT_O |-> SUMMARY_O)
    else $error("interrupt without summary");
  miss_gate_a: assert property (MISSED_FRAME_I && !m[12] |-> ##2 SUMMARY_O)
    else $error("missed frame not summarised");
  memory_error_flag_gate_a: assert property (MEMORY_ERROR_I && !m[11] |-> ##2 SUMMARY_O)
    else $error("memory error not summarised");
  receive_event_flag_gate_a: assert property (RX_LAST_WRITTEN_I && !m[10] |-> ##2 SUMMARY_O)
    else $error("receive event not summarised");
  transmit_event_flag_gate_a: assert property (TRANSMIT_DONE_I && !m[9] |-> ##2 SUMMARY_O)
    else $error("transmit event not summarised");
  init_done_flag_gate_a: assert property (INIT_DONE_I && !m[8] |-> ##2 SUMMARY_O)
    else $error("init done not summarised");
  transmit_underflow_error_stop_a: assert property (TRANSMIT_UNDERFLOW_I && !m[6] |-> ##2 !TRANSMIT_ON_O)
    else $error("transmitter kept on after underflow");
  lane_order_a: assert property (FIFO_TO_MEM_O == emem)
    else $error("fifo byte lanes wrong");
  start_hold_a: assert property (scan && DESC_START_I && DESC_OWNED_I
    |=> RX_START_SEEN_O && RX_HELD_DESC_O == $past(DESC_WORD_I)) else $error("start not held");
  host_poll_a: assert property (scan && DESC_START_I && !DESC_OWNED_I
    |=> !DESC_FETCH_O [*8]) else $error("host start refetched at once");
endmodule

bind interrupt_mask_deferral_ctrl imdc_monitor u_imdc_monitor (
  .CLOCK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .MISSED_FRAME_I,
  .MEMORY_ERROR_I, .TRANSMIT_DONE_I, .INIT_DONE_I, .TRANSMIT_UNDERFLOW_I, .RX_LAST_WRITTEN_I,
  .DESC_VALID_I, .DESC_OWNED_I, .DESC_START_I, .DESC_WORD_I, .FIFO_BUS_I, .SUMMARY_O,
  .INTERRUPT_O, .TRANSMIT_ON_O, .DESC_FETCH_O, .RX_START_SEEN_O, .RX_HELD_DESC_O,
  .FIFO_TO_MEM_O);

// ### sim/test_interrupt_mask_deferral_ctrl.sv
// self-checking bench for the mask/deferral register block
`timescale 1ns/1ps
module test_interrupt_mask_deferral_ctrl;
  reg         clk, rst_n, wr, rd, dv, dow, dst;
  reg  [3:0]  addr;
  reg  [7:0]  ev;
  reg  [2:0]  s;
  reg  [31:0] wd, dw, fb, fm;
  wire [31:0] rdata, held, tomem, tobus;
  wire        irq, sum, tx_on, resc, two, bo, fet, adv, clr, seen;
  integer     fail_count, n_tests, cyc, i, k;
  // ev: five event pulses, then underflow, first-buffer, frame-arrived
  interrupt_mask_deferral_ctrl u_interrupt_mask_deferral_ctrl (
    .CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .MISSED_FRAME_I(ev[4]), .MEMORY_ERROR_I(ev[3]), .TRANSMIT_DONE_I(ev[1]),
    .INIT_DONE_I(ev[0]), .TRANSMIT_UNDERFLOW_I(ev[5]), .RX_FIRST_WRITTEN_I(ev[6]),
    .RX_LAST_WRITTEN_I(ev[2]), .RX_FRAME_ARRIVED_I(ev[7]), .DESC_VALID_I(dv),
    .DESC_OWNED_I(dow), .DESC_START_I(dst), .DESC_WORD_I(dw), .FIFO_BUS_I(fb), .FIFO_MEM_I(fm),
    .INTERRUPT_O(irq), .SUMMARY_O(sum), .TRANSMIT_ON_O(tx_on), .TX_RESCAN_O(resc),
    .TWO_PART_OFF_O(two), .MOD_BACKOFF_O(bo), .DESC_FETCH_O(fet), .DESC_ADVANCE_O(adv),
    .DESC_CLEAR_OWN_O(clr), .RX_START_SEEN_O(seen), .RX_HELD_DESC_O(held),
    .FIFO_TO_MEM_O(tomem), .FIFO_TO_BUS_O(tobus));
  task chk(input [31:0] g, input [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  task complete_run;
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cy(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wrr(input [3:0] a, input [31:0] d);
    @(posedge clk);
    {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rdc(input [3:0] a, input [31:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task fire(input integer n);
    @(posedge clk);
    ev[n] <= 1'b1;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  // pulses may land one or two cycles late, so gather them over a window
  task wat;
    s = 3'h0;
    repeat (4) begin
      #1 s = s | {resc, adv, clr};
      @(posedge clk);
    end
    #1;
  endtask
  task dsc(input o, input t);
    @(posedge clk);
    {dv, dow, dst} <= {1'b1, o, t};
    @(posedge clk);
    dv <= 1'b0;
    wat;
  endtask
  // bounded wait: the host poll period is 200 cycles
  task wf;
    for (k = 0; fet !== 1'b1 && k < 300; k++) cy(1);
    chk(fet, 1'b1);
  endtask
  task t_regs;
    rdc(4'h0, 32'h0);
    wrr(4'h0, 32'hFFFFFFFF);
    rdc(4'h0, 32'h1F7F);
    rdc(4'h2, 32'h0);
    cy(2);
    chk({two, bo}, 2'b11);
    wrr(4'h8, 32'h4);
    rdc(4'h0, 32'h1F7F);
    wrr(4'h8, 32'h8);
    cy(3);
    rdc(4'h0, 32'h0);
    chk({two, bo}, 2'b00);
  endtask
  task t_mask;
    for (i = 0; i < 5; i++) begin
      wrr(4'h0, 32'h100 << i);
      wrr(4'h8, 32'h1);
      fire(i);
      cy(3);
      chk(sum, 1'b0);
      rdc(4'h4, 32'h1 << i);
      wrr(4'h0, 32'h0);
      cy(3);
      chk({sum, irq}, 2'b11);
      rdc(4'hC, 32'h3);
      wrr(4'h8, 32'h0);
      cy(3);
      chk({sum, irq}, 2'b10);
      wrr(4'h4, 32'h1 << i);
      cy(3);
      chk(sum, 1'b0);
    end
  endtask
  task t_transmit_underflow_error;
    wrr(4'h8, 32'h2);
    wrr(4'h0, 32'h40);
    fire(5);
    wat;
    chk({s[2], tx_on}, 2'b11);
    rdc(4'h8, 32'h2);
    wrr(4'h0, 32'h0);
    fire(5);
    wat;
    chk({s[2], tx_on}, 2'b00);
    rdc(4'h8, 32'h0);
  endtask
  task t_swap;
    wrr(4'h0, 32'h4);
    fb <= 32'h11223344;
    fm <= 32'hA1B2C3D4;
    cy(2);
    chk(tomem, 32'h44332211);
    chk(tobus, 32'hD4C3B2A1);
    rdc(4'h0, 32'h4);
    wrr(4'h0, 32'h0);
    cy(2);
    chk(tomem, 32'h11223344);
    chk(tobus, 32'hA1B2C3D4);
  endtask
  task t_scan;
    wrr(4'h0, 32'h20);
    fire(6);
    rdc(4'h4, 32'h4);
    wrr(4'h4, 32'h4);
    fire(2);
    wf;
    dsc(1'b1, 1'b0);
    chk(s[1:0], 2'b11);
    wf;
    dsc(1'b0, 1'b0);
    chk(s[1:0], 2'b10);
    wf;
    dsc(1'b0, 1'b1);
    chk(fet, 1'b0);
    wf;
    dsc(1'b1, 1'b1);
    chk({seen, fet, held}, {2'b10, 32'h5A5A0F0F});
    fire(7);
    cy(2);
    chk(seen, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    {rst_n, wr, rd, dv, dow, dst, addr, ev, wd, fb, fm} = 0;
    dw = 32'h5A5A0F0F;
    {fail_count, n_tests, cyc} = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_mask;
    t_transmit_underflow_error;
    t_swap;
    t_scan;
    complete_run;
  end
endmodule
